// ### logic/hdlc_params.svh
// Constants for the frame formatter: offsets, fields, reset values, counts
`ifndef HDLC_PARAMS_SVH
`define HDLC_PARAMS_SVH

// Line patterns and check arithmetic
`define FLAG_PATTERN 8'h7e
`define CRC_PRESET 16'hffff
`define CRC_POLY_REFL 16'h8408
`define CRC_RESIDUE 16'hf0b8
`define STUFF_RUN 3'd5
`define ABORT_PRE 3'd6
`define RUN_SAT 3'd7
`define MIN_FRAME_BITS 6'd25
`define BITS_SAT 6'd63
`define HOLD_BYTES 3'd4

// Register byte offsets, decoded on haddr[7:0]
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_STN0 8'h08
`define OFS_STN3 8'h14
`define OFS_MASK 8'h18

// Control field positions
`define CTRL_SHARE 0
`define CTRL_NOCRC 1
`define CTRL_SEARCH 2
`define CTRL_ALEN 4
`define CTRL_WMASK 32'h0000_0037

// Status field positions
`define STAT_FV 0
`define STAT_CE 1

// Reset values
`define CTRL_RST 32'h0000_0000
`define STN_RST 32'h0000_0000
`define MASK_RST 32'hffff_ffff

`endif

// ### logic/hdlc_pkg.sv
// Types shared by the frame formatter files
`default_nettype none
package hdlc_pkg;

  // One byte offered by the transmit queue
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tx_byte_s;

  // One byte handed to the receive queue
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_s;

  // End of a received frame
  typedef struct packed {
    logic done;
    logic good;
    logic aborted;
  } frame_end_s;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_OPEN = 5'b00010,
    TX_DATA = 5'b00100,
    TX_FCS = 5'b01000,
    TX_CLOSE = 5'b10000
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_FRAME = 2'b10
  } rx_state_e;

endpackage
`default_nettype wire

// ### logic/hdlc_crc16.sv
// Serial frame check register, one bit per step
`include "hdlc_params.svh"
`default_nettype none
module hdlc_crc16 (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic preset,
  input wire logic step,
  input wire logic data_bit,
  // Result; bit 0 holds the x15 term
  output logic [15:0] crc_q
);

  logic fb;
  logic [15:0] crc_d;

  // Reflected form of x16 + x12 + x5 + 1
  assign fb = crc_q[0] ^ data_bit;
  assign crc_d = {1'b0, crc_q[15:1]} ^ (fb ? `CRC_POLY_REFL : 16'h0000);

  // Preset wins over a step in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_q <= `CRC_PRESET;
    end else if (preset) begin
      crc_q <= `CRC_PRESET;
    end else if (step) begin
      crc_q <= crc_d;
    end
  end

endmodule
`default_nettype wire

// ### logic/hdlc_frame_core.sv
// Frame formatter and checker core with AHB-Lite register slave
//
// Overview of operation
// - Flag 01111110 generated and used for framing
// - Opening and closing flags added automatically
// - Frame carries address, control, information, check
// - Share bit selects one or two flags
// - Payload bytes go least significant bit first
// - Check field goes most significant bit first
// - Address length one to four bytes
// - Four station addresses and one mask
// - Matching frames passed whole, others dropped
// - Control byte passed like information bytes
// - Information in whole octets, may be absent
// - Both checkers use x16 + x12 + x5 + 1
// - Check registers preset to ones per frame
// - Transmit sends complement of final remainder
// - Receive residue F0B8 sets frame valid
// - Residue mismatch sets check error flag
// - No-check mode: no field sent, none checked
// - No-check mode passes every received byte
// - Frames of any length handled, no upper limit
// - Zero inserted and removed after five ones
// - Frames under 25 bits silently ignored
// - Seven ones abort the frame in progress
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`include "hdlc_params.svh"
`default_nettype none
module hdlc_frame_core (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Transmit queue side
  input wire hdlc_pkg::tx_byte_s tx_in,
  output logic tx_ready,
  // Receive queue side
  output var hdlc_pkg::rx_byte_s rx_out,
  output var hdlc_pkg::frame_end_s rx_end,
  // Serial line, one bit per tick
  input wire logic tx_bit_tick,
  output logic tx_line,
  input wire logic rx_bit_tick,
  input wire logic rx_line
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // First received address byte sits in bits 7:0
  function automatic logic addr_match(input logic [31:0] a, input logic [31:0] stn,
                                      input logic [31:0] m, input logic [1:0] alen);
    logic [31:0] used;
    used = 32'hffff_ffff >> {alen ^ 2'b11, 3'b000};
    addr_match = (((a ^ stn) & m & used) == 32'h0);
  endfunction

  // ---------------- Register slave ----------------
  logic [31:0] ctrl_q, mask_q, hrdata_q;
  logic [31:0] stn_q [4];
  logic wr_pend_q, fv_q, ce_q, hreadyout_q, hresp_q;
  logic [7:0] wr_addr_q;
  hdlc_pkg::tx_state_e tx_st_q, tx_st_d;
  hdlc_pkg::rx_state_e rx_st_q;

  // Address phase decode; only haddr[7:0] is decoded, so the map aliases
  wire bus_take = hsel & hready & htrans[1];
  wire [7:0] ra = haddr[7:0];
  wire [2:0] ra_idx = ra[4:2] - 3'd2;
  wire ra_stn = (ra >= `OFS_STN0) & (ra <= `OFS_STN3) & (ra[1:0] == 2'b00);
  wire [2:0] wa_idx = wr_addr_q[4:2] - 3'd2;
  wire wa_stn = (wr_addr_q >= `OFS_STN0) & (wr_addr_q <= `OFS_STN3) & (wr_addr_q[1:0] == 2'b00);
  wire wr_ctrl = wr_pend_q & hit(wr_addr_q, `OFS_CTRL);
  wire wr_stat = wr_pend_q & hit(wr_addr_q, `OFS_STAT);
  wire wr_mask = wr_pend_q & hit(wr_addr_q, `OFS_MASK);
  wire share = ctrl_q[`CTRL_SHARE];
  wire nocrc = ctrl_q[`CTRL_NOCRC];
  wire search = ctrl_q[`CTRL_SEARCH];
  wire [1:0] alen = ctrl_q[`CTRL_ALEN +: 2];
  wire [31:0] stat_word = {28'h0, tx_st_q != hdlc_pkg::TX_IDLE,
                           rx_st_q == hdlc_pkg::RX_FRAME, ce_q, fv_q};
  wire [31:0] rd_word = hit(ra, `OFS_CTRL) ? ctrl_q :
                        hit(ra, `OFS_STAT) ? stat_word :
                        ra_stn ? stn_q[ra_idx[1:0]] :
                        hit(ra, `OFS_MASK) ? mask_q : 32'h0;

  // Zero wait states; read data is captured at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= bus_take & hwrite;
      wr_addr_q <= bus_take ? ra : wr_addr_q;
      hrdata_q <= (bus_take & ~hwrite) ? rd_word : hrdata_q;
    end
  end

  // Writable registers, stored in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `CTRL_RST;
      mask_q <= `MASK_RST;
      for (int i = 0; i < 4; i++) stn_q[i] <= `STN_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata & `CTRL_WMASK;
      if (wr_mask) mask_q <= hwdata;
      if (wr_pend_q & wa_stn) stn_q[wa_idx[1:0]] <= hwdata;
    end
  end

  // ---------------- Transmitter ----------------
  logic [3:0] tx_cnt_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_ones_q;
  logic tx_last_q, tx_line_q, hold_v_q, tx_ready_q;
  hdlc_pkg::tx_byte_s hold_q;
  logic [15:0] tx_crc;

  wire [7:0] flag_pat = `FLAG_PATTERN;
  wire tx_in_data = (tx_st_q == hdlc_pkg::TX_DATA);
  wire tx_in_fcs = (tx_st_q == hdlc_pkg::TX_FCS);
  wire tx_in_flag = (tx_st_q == hdlc_pkg::TX_OPEN) | (tx_st_q == hdlc_pkg::TX_CLOSE);
  wire tx_stuffable = tx_in_data | tx_in_fcs | ((tx_st_q == hdlc_pkg::TX_CLOSE) & (tx_cnt_q == 4'd0));
  wire tx_stuff = tx_bit_tick & tx_stuffable & (tx_ones_q == `STUFF_RUN);
  wire tx_adv = tx_bit_tick & ~tx_stuff;
  wire tx_data_bit = tx_sh_q[0];
  wire tx_fcs_bit = ~tx_crc[tx_cnt_q];
  wire tx_flag_bit = flag_pat[tx_cnt_q[2:0]];
  wire tx_bit_val = tx_in_data ? tx_data_bit : tx_in_fcs ? tx_fcs_bit :
                    tx_in_flag ? tx_flag_bit : 1'b1;
  wire byte_end = tx_adv & tx_in_data & (tx_cnt_q == 4'd7);
  wire fcs_end = tx_adv & tx_in_fcs & (tx_cnt_q == 4'd15);
  wire flag_end = tx_adv & tx_in_flag & (tx_cnt_q == 4'd7);
  wire open_end = flag_end & (tx_st_q == hdlc_pkg::TX_OPEN);
  wire close_end = flag_end & (tx_st_q == hdlc_pkg::TX_CLOSE);
  wire close_to_data = close_end & hold_v_q & share;
  wire tx_load = open_end | (byte_end & ~tx_last_q & hold_v_q) | close_to_data;
  wire hold_wr = tx_in.valid & tx_ready_q;
  wire hold_v_d = hold_wr | (hold_v_q & ~tx_load);

  // Frame sequencing; running dry mid-frame drops to mark idle, an abort
  always_comb begin
    tx_st_d = tx_st_q;
    unique case (tx_st_q)
      hdlc_pkg::TX_IDLE: if (tx_bit_tick & hold_v_q) tx_st_d = hdlc_pkg::TX_OPEN;
      hdlc_pkg::TX_OPEN: if (open_end) tx_st_d = hdlc_pkg::TX_DATA;
      hdlc_pkg::TX_DATA: begin
        if (byte_end & tx_last_q) begin
          tx_st_d = nocrc ? hdlc_pkg::TX_CLOSE : hdlc_pkg::TX_FCS;
        end else if (byte_end & ~hold_v_q) begin
          tx_st_d = hdlc_pkg::TX_IDLE;
        end
      end
      hdlc_pkg::TX_FCS: if (fcs_end) tx_st_d = hdlc_pkg::TX_CLOSE;
      hdlc_pkg::TX_CLOSE: begin
        if (close_end) begin
          tx_st_d = !hold_v_q ? hdlc_pkg::TX_IDLE :
                    share ? hdlc_pkg::TX_DATA : hdlc_pkg::TX_OPEN;
        end
      end
      default: tx_st_d = hdlc_pkg::TX_IDLE;
    endcase
  end

  // Bit position, run of ones and line output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q <= hdlc_pkg::TX_IDLE;
      tx_cnt_q <= 4'd0;
      tx_ones_q <= 3'd0;
      tx_line_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      if (tx_adv & (tx_st_q != hdlc_pkg::TX_IDLE)) begin
        tx_cnt_q <= (flag_end | byte_end | fcs_end) ? 4'd0 : tx_cnt_q + 4'd1;
      end
      if (tx_bit_tick) begin
        tx_ones_q <= (~tx_stuff & (tx_in_data | tx_in_fcs) & tx_bit_val) ?
                     tx_ones_q + 3'd1 : 3'd0;
        tx_line_q <= tx_stuff ? 1'b0 : tx_bit_val;
      end
    end
  end

  // Single holding byte in front of the shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q <= '0;
      hold_v_q <= 1'b0;
      tx_ready_q <= 1'b1;
      tx_sh_q <= 8'h00;
      tx_last_q <= 1'b0;
    end else begin
      if (hold_wr) hold_q <= tx_in;
      hold_v_q <= hold_v_d;
      tx_ready_q <= ~hold_v_d;
      if (tx_load) begin
        tx_sh_q <= hold_q.data;
        tx_last_q <= hold_q.last;
      end else if (tx_adv & tx_in_data) begin
        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
      end
    end
  end

  hdlc_crc16 u_tx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .preset(open_end | close_to_data),
    .step(tx_adv & tx_in_data),
    .data_bit(tx_data_bit),
    .crc_q(tx_crc)
  );

  // ---------------- Receiver ----------------
  logic [7:0] win_q, byte_q;
  logic [2:0] run_q, dones_q, bcnt_q, nbytes_q;
  logic [3:0] skip_q;
  logic [5:0] bits_q;
  logic [31:0] rhold_q;
  logic [1:0] flush_idx_q;
  logic match_q, stream_q, flush_act_q, end_pend_q, was_frame_q, addr_chk_q, addr_any;
  hdlc_pkg::rx_byte_s rx_out_q;
  hdlc_pkg::frame_end_s rx_end_q;
  logic [15:0] rx_crc;

  wire rx_framing = (rx_st_q == hdlc_pkg::RX_FRAME);
  wire flag_hit = rx_bit_tick & ({rx_line, win_q[7:1]} == `FLAG_PATTERN);
  wire abort_hit = rx_bit_tick & rx_framing & rx_line & (run_q >= `ABORT_PRE);
  wire pop = win_q[0];
  wire pop_ok = rx_bit_tick & rx_framing & (skip_q == 4'd0) & ~abort_hit;
  wire pop_stuffed = pop_ok & (dones_q == `STUFF_RUN) & ~pop;
  wire data_ok = pop_ok & ~pop_stuffed;
  wire [7:0] byte_nxt = {pop, byte_q[7:1]};
  wire byte_done = data_ok & (bcnt_q == 3'd7);
  wire long_enough = (bits_q >= `MIN_FRAME_BITS);
  wire flush_start = rx_framing & match_q & ~stream_q & long_enough;
  wire [1:0] held_m1 = (nbytes_q >= `HOLD_BYTES) ? 2'd3 : nbytes_q[1:0] - 2'd1;
  wire rx_eval = end_pend_q & ~flush_act_q & ~flush_start;
  wire rx_eval_frame = rx_eval & was_frame_q & long_enough & match_q;
  wire rx_good = (bcnt_q == 3'd0) & (nocrc | (rx_crc == `CRC_RESIDUE));
  wire fv_d = (rx_eval_frame & rx_good) | (fv_q & ~(wr_stat & hwdata[`STAT_FV]));
  wire ce_d = (rx_eval_frame & ~rx_good) | (ce_q & ~(wr_stat & hwdata[`STAT_CE]));

  // Any station under the mask; with search off every frame matches
  always_comb begin
    addr_any = ~search;
    for (int i = 0; i < 4; i++) addr_any = addr_any | addr_match(rhold_q, stn_q[i], mask_q, alen);
  end

  // Raw line window, ones run and the skip over flag bits in the delay line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q <= 8'hff;
      run_q <= 3'd0;
      skip_q <= 4'd0;
    end else if (rx_bit_tick) begin
      win_q <= {rx_line, win_q[7:1]};
      run_q <= rx_line ? ((run_q == `RUN_SAT) ? run_q : run_q + 3'd1) : 3'd0;
      skip_q <= flag_hit ? 4'd8 : (skip_q != 4'd0) ? skip_q - 4'd1 : skip_q;
    end
  end

  // Framing state; a closing flag also opens the next frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q <= hdlc_pkg::RX_HUNT;
      end_pend_q <= 1'b0;
      was_frame_q <= 1'b0;
    end else begin
      if (abort_hit) rx_st_q <= hdlc_pkg::RX_HUNT;
      else if (rx_eval) rx_st_q <= hdlc_pkg::RX_FRAME;
      end_pend_q <= flag_hit | (end_pend_q & ~rx_eval);
      if (flag_hit) was_frame_q <= rx_framing;
    end
  end

  // Destuffed bit, byte and length counters; bit count saturates for long frames
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dones_q <= 3'd0;
      bcnt_q <= 3'd0;
      nbytes_q <= 3'd0;
      bits_q <= 6'd0;
      byte_q <= 8'h00;
    end else if (rx_eval) begin
      dones_q <= 3'd0;
      bcnt_q <= 3'd0;
      nbytes_q <= 3'd0;
      bits_q <= 6'd0;
    end else if (pop_ok) begin
      dones_q <= (pop_stuffed | ~pop) ? 3'd0 : dones_q + 3'd1;
      if (data_ok) begin
        bcnt_q <= bcnt_q + 3'd1;
        byte_q <= byte_nxt;
        bits_q <= (bits_q == `BITS_SAT) ? bits_q : bits_q + 6'd1;
        if (byte_done & (nbytes_q != 3'd7)) nbytes_q <= nbytes_q + 3'd1;
      end
    end
  end

  // Leading bytes wait here until the address and length are known
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rhold_q <= 32'h0;
      addr_chk_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      if (byte_done & ~stream_q & (nbytes_q < `HOLD_BYTES)) begin
        rhold_q[{nbytes_q[1:0], 3'b000} +: 8] <= byte_nxt;
      end
      addr_chk_q <= byte_done & (nbytes_q == {1'b0, alen});
      if (rx_eval) match_q <= 1'b0;
      else if (addr_chk_q) match_q <= addr_any;
    end
  end

  // Emission: flush held bytes, then pass each byte as it completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stream_q <= 1'b0;
      flush_act_q <= 1'b0;
      flush_idx_q <= 2'd0;
      rx_out_q <= '0;
      rx_end_q <= '0;
    end else begin
      if (rx_eval) stream_q <= 1'b0;
      else if (flush_start) stream_q <= 1'b1;
      flush_act_q <= flush_start | (flush_act_q & (flush_idx_q != held_m1));
      flush_idx_q <= flush_act_q ? flush_idx_q + 2'd1 : 2'd0;
      rx_out_q.valid <= flush_act_q | (byte_done & stream_q);
      rx_out_q.data <= flush_act_q ? rhold_q[{flush_idx_q, 3'b000} +: 8] : byte_nxt;
      rx_end_q.done <= rx_eval_frame | (abort_hit & stream_q);
      rx_end_q.good <= rx_eval_frame & rx_good;
      rx_end_q.aborted <= abort_hit & stream_q;
    end
  end

  // Sticky result flags; a new result wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fv_q <= 1'b0;
      ce_q <= 1'b0;
    end else begin
      fv_q <= fv_d;
      ce_q <= ce_d;
    end
  end

  hdlc_crc16 u_rx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .preset(rx_eval),
    .step(data_ok),
    .data_bit(pop),
    .crc_q(rx_crc)
  );

  // Outputs straight from flip-flops
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign tx_ready = tx_ready_q;
  assign tx_line = tx_line_q;
  assign rx_out = rx_out_q;
  assign rx_end = rx_end_q;

  // ---------------- Checks ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_fcs_last;
    tx_in_fcs ##0 fcs_end;
  endsequence

  flag_bits_a: assert property (tx_adv & tx_in_flag |=> tx_line_q == $past(tx_flag_bit))
    else $error("flag bit wrong on line");
  open_flag_a: assert property (tx_st_q == hdlc_pkg::TX_IDLE & tx_bit_tick & hold_v_q
    |=> tx_st_q == hdlc_pkg::TX_OPEN ##1 tx_st_q != hdlc_pkg::TX_DATA)
    else $error("frame not opened by a flag");
  close_after_fcs_a: assert property (s_fcs_last |=> tx_st_q == hdlc_pkg::TX_CLOSE)
    else $error("check field not followed by closing flag");
  share_select_a: assert property (close_end & hold_v_q
    |=> tx_st_q == ($past(share) ? hdlc_pkg::TX_DATA : hdlc_pkg::TX_OPEN))
    else $error("separator choice ignored");
  lsb_first_a: assert property (tx_adv & tx_in_data |=> tx_line_q == $past(tx_data_bit))
    else $error("payload bit order wrong");
  fcs_bit_a: assert property (tx_adv & tx_in_fcs |=> tx_line_q == $past(tx_fcs_bit))
    else $error("check field bit wrong");
  stuff_zero_a: assert property (tx_stuff |=> !tx_line_q ##0 tx_ones_q == 3'd0)
    else $error("zero not inserted after five ones");
  tx_preset_a: assert property (open_end |=> tx_crc == `CRC_PRESET)
    else $error("transmit check not preset");
  nocrc_close_a: assert property (byte_end & tx_last_q & nocrc |=> tx_st_q == hdlc_pkg::TX_CLOSE)
    else $error("check field sent in no-check mode");
  rx_valid_a: assert property (rx_eval_frame & rx_good |=> fv_q & rx_end_q.good)
    else $error("good frame not flagged valid");
  rx_crcerr_a: assert property (rx_eval_frame & !rx_good |=> ce_q & !rx_end_q.good)
    else $error("bad frame not flagged");
  short_drop_a: assert property (rx_eval & !long_enough |=> !$rose(fv_q) & !$rose(ce_q))
    else $error("short frame reported");
  abort_hunt_a: assert property (abort_hit |=> rx_st_q == hdlc_pkg::RX_HUNT ##1 !rx_out_q.valid)
    else $error("abort not honoured");
  status_hold_a: assert property (!rx_eval_frame |=> !$rose(fv_q) & !$rose(ce_q))
    else $error("status changed between frames");

endmodule
`default_nettype wire

// ### sim/far_station.sv
// Remote station model: bit clock, line listener and frame sender
`include "hdlc_params.svh"
`default_nettype none
module far_station (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial line
  output logic tick,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FLAG = `FLAG_PATTERN;
  logic [3:0] cnt_q;
  logic sq[$];
  logic bq[$];
  logic [7:0] got[$];
  int frames;
  int ones;

  // Queues a frame; left open, the idle ones that follow abort it
  task automatic send(input logic [7:0] b[$], input logic close);
    int run;
    run = 0;
    for (int k = 0; k < 8; k++) sq.push_back(FLAG[k]);
    foreach (b[i]) for (int k = 0; k < 8; k++) begin
      sq.push_back(b[i][k]);
      run = b[i][k] ? run + 1 : 0;
      if (run == 5) begin
        sq.push_back(1'b0);
        run = 0;
      end
    end
    for (int k = 0; k < 8 && close; k++) sq.push_back(FLAG[k]);
  endtask

  // Destuffs the line; a flag ends the frame, seven ones discard it
  task automatic hear(input logic b);
    logic [7:0] v;
    if (b) begin
      ones++;
      bq.push_back(b);
      if (ones >= 7) bq.delete();
    end else if (ones == 5) begin
      ones = 0;
    end else if (ones == 6) begin
      ones = 0;
      if (bq.size() >= 23) begin
        frames++;
        for (int i = 0; i + 8 <= bq.size() - 7; i += 8) begin
          for (int k = 0; k < 8; k++) v[k] = bq[i + k];
          got.push_back(v);
        end
      end
      bq.delete();
    end else begin
      ones = 0;
      bq.push_back(b);
    end
  endtask

  // One tick in ten cycles keeps ticks well apart for the receiver
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      tick <= 1'b0;
      rx_line <= 1'b1;
    end else begin
      cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
      tick <= (cnt_q == 4'h8);
      if (tick) begin
        if (sq.size() != 0) rx_line <= sq.pop_front();
        else rx_line <= 1'b1;
        hear(tx_line);
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the frame formatter core
`include "hdlc_params.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_ready, tick, tx_line, rx_line;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, seed, rd, junk;
  hdlc_pkg::tx_byte_s tx_in;
  hdlc_pkg::rx_byte_s rx_out;
  hdlc_pkg::frame_end_s rx_end, last_end;
  logic [8:0] txq[$];
  logic [7:0] rxq[$], fr[$], ex[$], all[$];
  logic [7:0] offs[5] = '{`OFS_CTRL, `OFS_STN0, `OFS_STN3, `OFS_MASK, 8'h40};
  logic [31:0] rsts[5] = '{`CTRL_RST, `STN_RST, `STN_RST, `MASK_RST, 32'h0};
  int mismatches, tests_run, nend, n0, t;

  hdlc_frame_core i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_in(tx_in), .tx_ready(tx_ready),
    .rx_out(rx_out), .rx_end(rx_end), .tx_bit_tick(tick), .tx_line(tx_line),
    .rx_bit_tick(tick), .rx_line(rx_line)
  );
  far_station i_far (
    .hclk(hclk), .hresetn(hresetn), .tick(tick), .tx_line(tx_line), .rx_line(rx_line)
  );

  // Clock of 20 ns
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected check field, reflected so it goes out low byte first
  function automatic logic [15:0] fcs(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `CRC_PRESET;
    foreach (b[i]) for (int k = 0; k < 8; k++)
      c = (c[0] ^ b[i][k]) ? (c >> 1) ^ `CRC_POLY_REFL : c >> 1;
    return ~c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmpq(input logic [7:0] a[$], input logic [7:0] b[$]);
    check(a.size(), b.size());
    foreach (b[i]) if (i < a.size()) check(a[i], b[i]);
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check(hresp, 1'b0);  // Slave must always answer OKAY
  endtask

  // Header bytes, then a run of ones to force stuffing, then random
  task automatic mk(input int n, input logic [15:0] h, input logic crc);
    logic [15:0] f;
    fr = {};
    for (int i = 0; i < n; i++) fr.push_back(i < 2 ? h[8 * i +: 8] : (i == 2 ? 8'hff : 8'(rnd())));
    ex = fr;
    f = fcs(fr);
    if (crc) ex = {ex, f[7:0], f[15:8]};
  endtask

  // Far end sends a frame; status is read and cleared afterwards
  task automatic rx_case(input int n, input logic [15:0] h, input logic crc, input logic bad,
                         input logic close, input int ends, input logic [2:0] code,
                         input logic [31:0] st);
    mk(n, h, crc);
    if (bad) ex[n] = ~ex[n];
    rxq = {};
    n0 = nend;
    i_far.send(ex, close);
    for (t = 0; t < 9000 && i_far.sq.size() != 0; t++) @(posedge hclk);
    repeat (200) @(posedge hclk);
    ahb(1'b0, `OFS_STAT, 32'h0, rd);
    ahb(1'b1, `OFS_STAT, 32'h3, junk);
    check(nend - n0, ends);
    if (ends != 0) check(last_end, code);
    if (ends != 0 && close) cmpq(rxq, ex);
    if (ends == 0) check(rxq.size(), 0);
    check(rd & 32'h3, st);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Transmit feeder and receive collector
  always @(posedge hclk) begin
    if (tx_in.valid && tx_ready) void'(txq.pop_front());
    tx_in <= (txq.size() != 0) ? {1'b1, txq[0]} : 10'h000;
    if (rx_out.valid) rxq.push_back(rx_out.data);
    if (rx_end.done) begin
      nend++;
      last_end = rx_end;
    end
  end

  // Ceiling sits far above the roughly 8k to 9k cycles the run needs
  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    stop_test();
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    tx_in = '0;
    seed = 32'h48aa;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (offs[i]) begin
      ahb(1'b0, offs[i], 32'h0, rd);
      check(rd, rsts[i]);
    end
    // Transmit: plain, shared flag with two frames, then no check field
    for (int m = 0; m < 3; m++) begin
      ahb(1'b1, `OFS_CTRL, m, junk);
      i_far.got = {};
      n0 = i_far.frames;
      all = {};
      for (int j = 0; j <= (m == 1); j++) begin
        mk(3 + m + j, 16'(rnd()), m != 2);
        foreach (fr[i]) txq.push_back({i == fr.size() - 1, fr[i]});
        all = {all, ex};
      end
      for (t = 0; t < 9000 && i_far.frames - n0 < 1 + (m == 1); t++) @(posedge hclk);
      check(i_far.frames - n0, 1 + (m == 1));
      cmpq(i_far.got, all);
    end
    ahb(1'b1, `OFS_CTRL, 32'h0, junk);
    rx_case(5, 16'(rnd()), 1, 0, 1, 1, 3'b110, 32'h1);
    rx_case(4, 16'(rnd()), 1, 1, 1, 1, 3'b100, 32'h2);
    rx_case(1, 16'(rnd()), 1, 0, 1, 0, 3'b000, 32'h0);
    rx_case(6, 16'(rnd()), 1, 0, 0, 1, 3'b101, 32'h0);
    ahb(1'b1, `OFS_CTRL, 32'h2, junk);
    rx_case(4, 16'(rnd()), 0, 0, 1, 1, 3'b110, 32'h1);
    ahb(1'b1, `OFS_STN0 + 8'h08, {16'(rnd()), 16'ha55a}, junk);
    ahb(1'b1, `OFS_MASK, 32'h0000ffff, junk);
    ahb(1'b1, `OFS_CTRL, 32'h14, junk);
    rx_case(4, 16'ha55a, 1, 0, 1, 1, 3'b110, 32'h1);
    rx_case(4, 16'h005a, 1, 0, 1, 0, 3'b000, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
